// file: src/adc_pkg.sv
package adc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [31:0] ADDR_ENABLE = 32'h10070000;
   localparam logic [31:0] ADDR_CONFIG = 32'h10070004;
   localparam logic [31:0] ADDR_CONTROL = 32'h10070008;
   localparam logic [31:0] ADDR_STATUS = 32'h1007000C;
   localparam logic [31:0] ADDR_SAME = 32'h10070010;
   localparam logic [31:0] ADDR_WAIT = 32'h10070014;
   localparam logic [31:0] ADDR_TOUCH = 32'h10070018;
   localparam logic [31:0] ADDR_BATTERY = 32'h1007001C;
   localparam logic [31:0] ADDR_AUX = 32'h10070020;

   // ----------------------------------------
   // Reset values and masks
   // ----------------------------------------
   localparam logic [2:0] ENABLE_RESET = 3'h0;
   localparam logic [31:0] CONFIG_RESET = 32'h0002002C;
   localparam logic [31:0] CONFIG_WMASK = 32'hC007FFFF;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [2:0] STATUS_RESET = 3'h0;
   localparam logic [15:0] INTERVAL_RESET = 16'h0000;
   localparam logic [31:0] TOUCH_RESET = 32'h00000000;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int EN_AUX = 0;
   localparam int EN_BAT = 1;
   localparam int EN_TOUCH = 2;
   localparam int EN_BUSY = 7;
   localparam int CFG_PAIR = 31;
   localparam int CFG_DIFF = 30;
   localparam int CFG_PICK_LO = 16;
   localparam int CFG_DMA = 15;
   localparam int CFG_SEQ_LO = 13;
   localparam int CFG_SNUM_LO = 10;

   localparam logic [1:0] SEQ_XY = 2'h0;
   localparam logic [1:0] SEQ_XYZ = 2'h1;
   localparam logic [1:0] SEQ_XYZZ = 2'h2;

   typedef enum logic [2:0] {
      CH_AUX = 3'h0, CH_BAT = 3'h1, CH_X = 3'h2, CH_Y = 3'h3,
      CH_Z1 = 3'h4, CH_Z2 = 3'h5, CH_Z3 = 3'h6, CH_Z4 = 3'h7
   } chan_t;

   typedef enum logic [1:0] {
      K_AUX = 2'h0, K_BAT = 2'h1, K_TOUCH = 2'h2
   } kind_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_START = 3'h1, S_WAIT = 3'h2, S_GAP = 3'h3,
      S_FINISH = 3'h4, S_DELIVER = 3'h5, S_TAKE = 3'h6, S_REST = 3'h7
   } st_t;
endpackage

// file: src/pick_if.sv
`timescale 1ns/1ps
interface pick_if;
   logic clear;
   logic take;
   logic [11:0] data;
   logic [2:0] pick;
   logic [2:0] last;
   logic step_done;
   logic [11:0] value;
   modport ctrl (output clear, take, data, pick, last, input step_done, value);
   modport picker (input clear, take, data, pick, last, output step_done, value);
endinterface

// file: src/sample_picker.sv
`timescale 1ns/1ps
module sample_picker (
   input wire logic ref_clk,
   input wire logic reset,
   pick_if.picker p
);
   import adc_pkg::*;

   typedef struct packed {
      logic [2:0] cnt;
      logic [11:0] held;
   } pick_state_t;

   pick_state_t q;
   pick_state_t next_q;
   logic [2:0] target;
   logic match;

   // A pick beyond the repeat count falls back to the final sample
   assign target = (p.pick > p.last) ? p.last : p.pick;
   assign match = p.take && (q.cnt == target);
   assign p.step_done = p.take && (q.cnt == p.last);
   assign p.value = match ? p.data : q.held;

   always_comb begin
      next_q = q;
      if (p.clear) begin
         next_q.cnt = 3'h0;
      end else if (p.take) begin
         next_q.cnt = p.step_done ? 3'h0 : q.cnt + 3'h1;
         if (match) begin
            next_q.held = p.data;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule

// file: src/sar_adc_controller.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module sar_adc_controller (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic conv_start,
   output adc_pkg::chan_t conv_chan,
   output logic drive_diff,
   input wire logic conv_done,
   input wire logic [11:0] conv_data,
   output logic dma_req,
   input wire logic dma_ack
);
   import adc_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      st_t st;
      kind_t kind;
      chan_t chan;
      logic [1:0] step;
      logic word;
      logic pair_alt;
      logic [15:0] gap;
      logic [3:0][11:0] hold;
      logic [2:0] en;
      logic [31:0] cfg;
      logic [7:0] ctrl;
      logic [2:0] status;
      logic [15:0] same;
      logic [15:0] waitv;
      logic [31:0] touch;
      logic [15:0] bat;
      logic [15:0] aux;
      logic [31:0] rdata;
      logic dma_req;
      logic diff;
   } ctl_state_t;

   ctl_state_t q;
   ctl_state_t next_q;
   pick_if pk ();
   logic [1:0] seq;
   logic [1:0] last;
   logic wr_en;
   logic wr_cfg;
   logic wr_stat;
   logic touch_rd;
   logic consumed;

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   function automatic logic [1:0] last_step(input logic [1:0] s);
      case (s)
         SEQ_XYZ: last_step = 2'h2;
         SEQ_XYZZ: last_step = 2'h3;
         default: last_step = 2'h1;
      endcase
   endfunction

   function automatic chan_t step_chan(input logic [1:0] s,
                                       input logic [1:0] n,
                                       input logic alt);
      case (n)
         2'h0: step_chan = CH_X;
         2'h1: step_chan = CH_Y;
         2'h2: step_chan = (s == SEQ_XYZZ && alt) ? CH_Z3 : CH_Z1;
         default: step_chan = alt ? CH_Z4 : CH_Z2;
      endcase
   endfunction

   // Pressure pair always drives differentially; the single Z is single-ended
   function automatic logic diff_for(input logic [1:0] s,
                                     input logic [1:0] n,
                                     input logic sel);
      if (s == SEQ_XYZZ) begin
         diff_for = 1'b1;
      end else if (s == SEQ_XYZ && n == 2'h2) begin
         diff_for = 1'b0;
      end else begin
         diff_for = sel;
      end
   endfunction

   assign seq = q.cfg[CFG_SEQ_LO +: 2];
   assign last = last_step(seq);
   assign wr_en = reg_wr && reg_addr == ADDR_ENABLE;
   assign wr_cfg = reg_wr && reg_addr == ADDR_CONFIG;
   assign wr_stat = reg_wr && reg_addr == ADDR_STATUS;
   assign touch_rd = reg_rd && reg_addr == ADDR_TOUCH;
   assign consumed = q.dma_req ? dma_ack : touch_rd;

   // ----------------------------------------
   // Repeated-sample picker
   // ----------------------------------------
   // Sample selection
   assign pk.clear = q.st == S_IDLE;
   assign pk.take = q.st == S_WAIT && conv_done && q.kind == K_TOUCH;
   assign pk.data = conv_data;
   assign pk.pick = q.cfg[CFG_PICK_LO +: 3];
   assign pk.last = q.cfg[CFG_SNUM_LO +: 3];

   sample_picker u_picker (
      .ref_clk(ref_clk),
      .reset(reset),
      .p(pk.picker)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_q = q;
      next_q.rdata = 32'h00000000;
      case (q.st)
         S_IDLE: begin
            if (q.en[EN_AUX]) begin
               next_q.kind = K_AUX;
               next_q.chan = CH_AUX;
               next_q.diff = 1'b0;
               next_q.st = S_START;
            end else if (q.en[EN_BAT]) begin
               next_q.kind = K_BAT;
               next_q.chan = CH_BAT;
               next_q.diff = 1'b0;
               next_q.st = S_START;
            end else if (q.en[EN_TOUCH]) begin
               next_q.kind = K_TOUCH;
               next_q.step = 2'h0;
               next_q.word = 1'b0;
               next_q.hold = '0;
               next_q.chan = step_chan(seq, 2'h0, q.pair_alt);
               next_q.diff = diff_for(seq, 2'h0, q.cfg[CFG_DIFF]);
               next_q.st = S_START;
            end
         end
         S_START: begin
            next_q.st = S_WAIT;
         end
         S_WAIT: begin
            if (conv_done) begin
               case (q.kind)
                  K_AUX: begin
                     next_q.aux = {4'h0, conv_data};
                     next_q.st = S_FINISH;
                  end
                  K_BAT: begin
                     next_q.bat = {4'h0, conv_data};
                     next_q.st = S_FINISH;
                  end
                  default: begin
                     next_q.gap = q.same;
                     next_q.st = S_GAP;
                     if (pk.step_done) begin
                        next_q.hold[q.step] = pk.value;
                        if (q.step == last) begin
                           next_q.st = S_DELIVER;
                        end else if (!q.en[EN_TOUCH]) begin
                           next_q.st = S_IDLE;
                        end else begin
                           next_q.step = q.step + 2'h1;
                           next_q.chan = step_chan(seq, q.step + 2'h1, q.pair_alt);
                           next_q.diff = diff_for(seq, q.step + 2'h1, q.cfg[CFG_DIFF]);
                        end
                     end
                  end
               endcase
            end
         end
         S_GAP: begin
            next_q.gap = q.gap - 16'h0001;
            if (q.gap == 16'h0000) begin
               next_q.st = S_START;
            end
         end
         S_FINISH: begin
            // Enable drops one cycle after the result lands
            if (q.kind == K_AUX) begin
               next_q.en[EN_AUX] = 1'b0;
            end else begin
               next_q.en[EN_BAT] = 1'b0;
            end
            next_q.st = S_IDLE;
         end
         S_DELIVER: begin
            if (q.word) begin
               next_q.touch = {4'h0, q.hold[3], 4'h0, q.hold[2]};
            end else begin
               next_q.touch = {4'h0, q.hold[1], 4'h0, q.hold[0]};
            end
            next_q.dma_req = q.cfg[CFG_DMA];
            next_q.st = S_TAKE;
         end
         S_TAKE: begin
            // The sequence stalls until the word is taken, so nothing is lost
            if (consumed) begin
               next_q.dma_req = 1'b0;
               if (!q.word && last != 2'h1) begin
                  next_q.word = 1'b1;
                  next_q.st = S_DELIVER;
               end else begin
                  next_q.pair_alt = q.pair_alt ^ q.cfg[CFG_PAIR];
                  next_q.gap = q.waitv;
                  next_q.st = S_REST;
               end
            end
         end
         S_REST: begin
            next_q.gap = q.gap - 16'h0001;
            if (q.gap == 16'h0000) begin
               next_q.st = S_IDLE;
            end
         end
         default: begin
            next_q.st = S_IDLE;
         end
      endcase

      // Software writes come after the hardware clear so a fresh request wins
      if (wr_en) begin
         next_q.en = reg_wdata[2:0];
      end
      if (wr_cfg) begin
         next_q.cfg = reg_wdata & CONFIG_WMASK;
      end
      if (reg_wr && reg_addr == ADDR_CONTROL) begin
         next_q.ctrl = reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == ADDR_SAME) begin
         next_q.same = reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == ADDR_WAIT) begin
         next_q.waitv = reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == ADDR_TOUCH && q.st != S_DELIVER) begin
         next_q.touch = reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_BATTERY && !(q.st == S_WAIT && q.kind == K_BAT)) begin
         next_q.bat = reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == ADDR_AUX && !(q.st == S_WAIT && q.kind == K_AUX)) begin
         next_q.aux = reg_wdata[15:0];
      end

      // Ready flags: write one to clear, a touch read clears too, set wins
      if (wr_stat) begin
         next_q.status = q.status & ~reg_wdata[2:0];
      end
      if (touch_rd) begin
         next_q.status[EN_TOUCH] = 1'b0;
      end
      if (q.st == S_FINISH) begin
         next_q.status[q.kind == K_AUX ? EN_AUX : EN_BAT] = 1'b1;
      end
      if (q.st == S_DELIVER && !q.cfg[CFG_DMA]) begin
         next_q.status[EN_TOUCH] = 1'b1;
      end

      if (reg_rd) begin
         case (reg_addr)
            // Bit 7 shows busy, 6:3 zero
            ADDR_ENABLE: next_q.rdata = {24'h0, q.st != S_IDLE, 4'h0, q.en};
            ADDR_CONFIG: next_q.rdata = q.cfg;
            ADDR_CONTROL: next_q.rdata = {24'h0, q.ctrl};
            ADDR_STATUS: next_q.rdata = {29'h0, q.status};
            ADDR_SAME: next_q.rdata = {16'h0, q.same};
            ADDR_WAIT: next_q.rdata = {16'h0, q.waitv};
            ADDR_TOUCH: next_q.rdata = q.touch;
            ADDR_BATTERY: next_q.rdata = {16'h0, q.bat};
            ADDR_AUX: next_q.rdata = {16'h0, q.aux};
            default: next_q.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         q <= '0;
         q.st <= S_IDLE;
         q.en <= ENABLE_RESET;
         q.cfg <= CONFIG_RESET;
         q.ctrl <= CONTROL_RESET;
         q.status <= STATUS_RESET;
         q.same <= INTERVAL_RESET;
         q.waitv <= INTERVAL_RESET;
         q.touch <= TOUCH_RESET;
         q.bat <= RESULT_RESET;
         q.aux <= RESULT_RESET;
      end else begin
         q <= next_q;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Conversion kick and channel
   assign conv_start = q.st == S_START;
   assign conv_chan = q.chan;
   assign drive_diff = q.diff;
   assign dma_req = q.dma_req;
   assign reg_rdata = q.rdata;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_aux_first: assert property (
      q.st == S_IDLE && q.en[EN_AUX] |=> conv_start && conv_chan == CH_AUX)
      else $error("aux request not served first");

   a_bat_second: assert property (
      q.st == S_IDLE && !q.en[EN_AUX] && q.en[EN_BAT]
      |=> conv_start && conv_chan == CH_BAT)
      else $error("battery not served before touch");

   a_aux_result: assert property (
      q.st == S_WAIT && conv_done && q.kind == K_AUX && !reg_wr
      |=> q.aux == {4'h0, $past(conv_data)} && q.st == S_FINISH)
      else $error("aux result not stored before enable clear");

   a_aux_clear: assert property (
      q.st == S_FINISH && q.kind == K_AUX && !wr_en |=> !q.en[EN_AUX])
      else $error("aux enable not cleared");

   a_bat_clear: assert property (
      q.st == S_FINISH && q.kind == K_BAT && !wr_en
      |=> !q.en[EN_BAT] ##1 q.st != S_FINISH)
      else $error("battery enable not cleared");

   a_enable_read: assert property (
      reg_rd && reg_addr == ADDR_ENABLE |=> reg_rdata[6:3] == 4'h0
      && reg_rdata[EN_BUSY] == ($past(q.st) != S_IDLE))
      else $error("enable readback wrong");

   a_cfg_reset: assert property (
      $fell(reset) |-> q.cfg == CONFIG_RESET)
      else $error("configuration reset value wrong");

   a_dma_hold: assert property (
      dma_req && !dma_ack |=> dma_req)
      else $error("dma request dropped early");

   a_dma_touch: assert property (
      dma_req |-> q.kind == K_TOUCH && q.cfg[CFG_DMA])
      else $error("dma used for a non-touch result");

   a_pair_diff: assert property (
      conv_start && q.kind == K_TOUCH && seq == SEQ_XYZZ |-> drive_diff)
      else $error("pressure pair not differential");

   a_y_after_x: assert property (
      conv_start && conv_chan == CH_Y |-> q.step == 2'h1)
      else $error("Y step out of order");

   c_aux_conv: cover property (q.st == S_FINISH && q.kind == K_AUX);
   c_all_enables: cover property (q.st == S_IDLE && q.en == 3'h7);
   c_dma_taken: cover property (dma_req && dma_ack);
   c_pressure: cover property (conv_start && conv_chan == CH_Z4);
endmodule

// file: tb/adc_converter_model.sv
`timescale 1ns/1ps
module adc_converter_model (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic conv_start,
   input wire adc_pkg::chan_t conv_chan,
   input wire logic [3:0] latency,
   output logic conv_done,
   output logic [11:0] conv_data
);
   import adc_pkg::*;

   // ----------------------------------------
   // Conversion timing and result pattern
   // ----------------------------------------
   // The result names its channel and its place in a run of samples on that
   // channel, so the bench can tell which repeated sample got reported.
   logic busy;
   logic [3:0] left;
   logic [3:0] last_chan;
   logic [7:0] run;
   logic [11:0] cur;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         busy <= 1'b0;
         left <= 4'h0;
         last_chan <= 4'hF;
         run <= 8'h00;
         cur <= 12'h000;
         conv_done <= 1'b0;
         conv_data <= 12'hFFF;
      end else begin
         conv_done <= 1'b0;
         // Released data toggles every cycle so a late capture cannot match
         conv_data <= ~conv_data;
         if (conv_start) begin
            busy <= 1'b1;
            left <= latency;
            last_chan <= {1'b0, conv_chan};
            if ({1'b0, conv_chan} == last_chan) begin
               run <= run + 8'h01;
               cur <= {1'b1, conv_chan, run + 8'h01};
            end else begin
               run <= 8'h00;
               cur <= {1'b1, conv_chan, 8'h00};
            end
         end else if (busy) begin
            if (left == 4'h0) begin
               busy <= 1'b0;
               conv_done <= 1'b1;
               conv_data <= cur;
            end else begin
               left <= left - 4'h1;
            end
         end
      end
   end
endmodule

// file: tb/sar_adc_controller_tb_top.sv
`timescale 1ns/1ps
`define CHECK(nm, ex, got) \
   begin \
      compares++; \
      if ((got) !== (ex)) begin \
         bad_count++; \
         $display("unexpected %s expected %h seen %h", nm, ex, got); \
      end \
   end

module sar_adc_controller_tb_top;
   import adc_pkg::*;

   logic ref_clk, reset, reg_wr, reg_rd, conv_start, drive_diff, conv_done, dma_req, dma_ack;
   logic [31:0] reg_addr, reg_wdata, reg_rdata;
   logic [11:0] conv_data;
   logic [3:0] latency;
   chan_t conv_chan;
   int bad_count = 0;
   int compares = 0;
   logic [2:0] chan_q[$];
   logic diff_q[$];

   sar_adc_controller i_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .conv_start(conv_start), .conv_chan(conv_chan), .drive_diff(drive_diff),
      .conv_done(conv_done), .conv_data(conv_data), .dma_req(dma_req), .dma_ack(dma_ack));

   adc_converter_model i_conv (.ref_clk(ref_clk), .reset(reset), .conv_start(conv_start),
      .conv_chan(conv_chan), .latency(latency), .conv_done(conv_done),
      .conv_data(conv_data));

   // ----------------------------------------
   // Clock, conversion log, watchdog
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (conv_start === 1'b1) begin
         chan_q.push_back(conv_chan);
         diff_q.push_back(drive_diff);
      end
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      finish_test();
   end

   // ----------------------------------------
   // Bus and delivery tasks
   // ----------------------------------------
   task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [31:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic check_reg(input logic [31:0] a, input logic [31:0] e, input string nm);
      logic [31:0] got;
      reg_read(a, got);
      `CHECK(nm, e, got)
   endtask

   // Polls are bounded so a stuck sequencer shows up as a mismatch
   task automatic wait_reg(input logic [31:0] a, input logic [31:0] m, input logic [31:0] w,
      input string nm);
      logic [31:0] v;
      int i;
      v = ~w;
      for (i = 0; i < 200 && (v & m) !== w; i++) reg_read(a, v);
      `CHECK(nm, w, v & m)
   endtask

   task automatic take_word(input logic [31:0] e);
      int i;
      for (i = 0; i < 2000 && dma_req !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      `CHECK("dma_req raised", 1'b1, dma_req)
      check_reg(ADDR_TOUCH, e, "dma touch word");
      @(posedge ref_clk);
      dma_ack <= 1'b1;
      @(posedge ref_clk);
      dma_ack <= 1'b0;
      #1;
      `CHECK("dma_req dropped", 1'b0, dma_req)
   endtask

   task automatic do_reset();
      reset <= 1'b1;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      chan_q.delete();
      diff_q.delete();
   endtask

   task automatic finish_test();
      if (bad_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      reset = 1'b1;
      reg_addr = 32'h00000000;
      reg_wdata = 32'h00000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      dma_ack = 1'b0;
      latency = 4'h0;
      do_reset();
      check_reg(ADDR_ENABLE, 32'h00000000, "enable reset");
      check_reg(ADDR_CONFIG, 32'h0002002C, "config reset");
      check_reg(ADDR_CONTROL, 32'h00000000, "control reset");
      check_reg(ADDR_STATUS, 32'h00000000, "status reset");
      check_reg(ADDR_SAME, 32'h00000000, "same interval reset");
      check_reg(ADDR_WAIT, 32'h00000000, "wait interval reset");
      check_reg(ADDR_TOUCH, 32'h00000000, "touch reset");
      check_reg(ADDR_BATTERY, 32'h00000000, "battery reset");
      check_reg(ADDR_AUX, 32'h00000000, "aux reset");
      check_reg(32'h10070024, 32'h00000000, "unmapped");
      reg_write(ADDR_ENABLE, 32'h000000F8);
      check_reg(ADDR_ENABLE, 32'h00000000, "enable reserved");
      reg_write(ADDR_CONFIG, 32'hFFFFFFFF);
      check_reg(ADDR_CONFIG, 32'hC007FFFF, "config writable");
      reg_write(ADDR_CONTROL, 32'h000000FF);
      check_reg(ADDR_CONTROL, 32'h000000FF, "control writable");
      reg_write(ADDR_CONFIG, CONFIG_RESET);

      // Slow converter on the auxiliary input
      latency <= 4'h9;
      reg_write(ADDR_ENABLE, 32'h00000001);
      wait_reg(ADDR_ENABLE, 32'h00000001, 32'h00000000, "aux enable cleared");
      check_reg(ADDR_AUX, 32'h00000800, "aux result");
      `CHECK("aux channel", CH_AUX, chan_q[0])

      // Prompt converter on the battery input
      latency <= 4'h0;
      reg_write(ADDR_ENABLE, 32'h00000002);
      wait_reg(ADDR_ENABLE, 32'h00000002, 32'h00000000, "battery cleared");
      check_reg(ADDR_BATTERY, 32'h00000900, "battery result");

      // All three at once, touch by processor reads
      chan_q.delete();
      diff_q.delete();
      reg_write(ADDR_ENABLE, 32'h00000007);
      wait_reg(ADDR_STATUS, 32'h00000004, 32'h00000004, "touch ready");
      wait_reg(ADDR_ENABLE, 32'h00000007, 32'h00000004, "enables after");
      for (int i = 0; i < 4; i++) begin
         `CHECK("priority order", 3'(i), chan_q[i])
      end
      `CHECK("single ended x", 1'b0, diff_q[2])
      `CHECK("single ended y", 1'b0, diff_q[3])
      `CHECK("no dma in cpu mode", 1'b0, dma_req)
      // Touch off while the word is unread, so no further point starts after it
      reg_write(ADDR_ENABLE, 32'h00000000);
      check_reg(ADDR_TOUCH, 32'h0B000A00, "touch xy word");
      check_reg(ADDR_BATTERY, 32'h00000900, "battery by cpu");
      check_reg(ADDR_AUX, 32'h00000800, "aux by cpu");
      wait_reg(ADDR_ENABLE, 32'h00000080, 32'h00000000, "idle after xy");

      // Reset while idle, then pressure pair by DMA, three samples, second kept
      do_reset();
      reg_write(ADDR_CONFIG, 32'h0001C82C);
      reg_write(ADDR_ENABLE, 32'h00000004);
      take_word(32'h0B010A01);
      take_word(32'h0D010C01);
      reg_write(ADDR_ENABLE, 32'h00000000);
      wait_reg(ADDR_ENABLE, 32'h00000080, 32'h00000000, "idle after pair");
      for (int i = 0; i < 12; i++) begin
         `CHECK("pair step channel", 3'(2 + i / 3), chan_q[i])
         `CHECK("pair differential", 1'b1, diff_q[i])
      end
      finish_test();
   end
endmodule
